// file: core/sar_adc_conversion_control.sv
// Purpose: sequencing and bus logic of an 8-bit successive-approx converter
// Assumes: i_cmp_high is the comparator answer for the trial code o_trial
// Notes:   data bus is two signals; host drives tri-state from enable
// Functional notes
// [RL1] eight MSB-first comparisons, latch, then interrupt
// [RL2] straight binary, all ones full scale
// [RL3] new start aborts running conversion
// [RL4] done output tied to start runs continuously
// [RL5] start falling edge clears approximation and shifter
// [RL6] chip select and start low holds reset
// [RL7] conversion begins 1 to 8 periods after release
// [RL8] start flop clears shifter, interrupt, loads entry
// [RL9] start flop cleared by tick after release
// [RL10] internal sequencing at one eighth clock
// [RL11] marker exit transfers result, then sets interrupt
// [RL12] interrupt set pulse lasts eight clock periods
// [RL13] free-run restart cuts interrupt to about 300 ns; the code cuts it after three clock periods, 75 ns
// [RL14] chip select and read clear interrupt, drive data
// [RL15] host pulses start once after power-up
// [RL16] host reads no sooner than eight periods after
// [RL17] conversion starts on start strobe rising edge
// [RL18] outputs high impedance unless chip select and read
`timescale 1ns/10ps
`include "sar_ctl_defines.svh"
module sar_adc_conversion_control #(
  parameter int BITS = `SAR_RES_BITS
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // host strobes, active low, asynchronous pins
  input  wire logic                   i_cs_n,
  input  wire logic                   i_start_n,
  input  wire logic                   i_rd_n,
  // analog side
  input  wire logic                   i_cmp_high,
  output logic [BITS-1:0]             o_trial,
  // host side
  output logic                        o_conversion_done_n,
  output sar_ctl_pkg::sample_type     o_data,
  output logic                        o_data_oe
);
  import sar_ctl_pkg::*;

  typedef struct packed {
    logic [1:0]      cs_s;
    logic [1:0]      st_s;
    logic [1:0]      rd_s;
    logic            st_prev;
    logic            start_ff;
    logic            shift_entry_flop;
    logic [BITS:0]   shifter;
    logic [BITS-1:0] approx_register;
    logic [BITS-1:0] trial;
    sample_type      result;
    logic            conversion_done_n_ff;
    logic            end_latch;
    logic            set_pend;
    logic [3:0]      set_cnt;
    logic            done_n;
    logic            oe;
    sample_type      dout;
    phase_type       phase;
  } ctl_type;

  ctl_type r, next_r;
  tick_if  tk ();

  initial begin
    if (BITS != `SAR_RES_BITS) $error("only 8-bit width supported");
    // set pulse count must fit the four-bit counter
    if (`SAR_DIV_RATIO > 15) $error("set pulse counter too narrow");
  end

  sar_tick_div #(.RATIO(`SAR_DIV_RATIO)) u_div (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .tk     (tk)
  );

  logic start_req;
  logic rd_req;
  logic marker_out;
  assign start_req  = !r.cs_s[1] && !r.st_s[1];
  assign rd_req     = !r.cs_s[1] && !r.rd_s[1];
  assign marker_out = r.shifter[BITS];
  // held start keeps the divider at phase zero, so release latency is bounded
  assign tk.restart = start_req; // RL7

  logic [BITS-1:0] next_approx_bit;
  logic [BITS-1:0] next_trial_bit;
  // per-bit search step: decide this bit, arm the next lower one
  for (genvar p = 0; p < BITS; p++) begin : g_bit
    assign next_approx_bit[p] = r.shifter[BITS-1-p] ? i_cmp_high
                                                    : r.approx_register[p];
    if (p == BITS - 1) begin : g_top
      assign next_trial_bit[p] = r.shifter[0] ? i_cmp_high : r.trial[p];
    end else begin : g_low
      assign next_trial_bit[p] = r.shifter[BITS-1-p] ? i_cmp_high
                               : r.shifter[BITS-2-p] ? 1'b1
                               : r.trial[p];
    end
  end

  always_comb begin
    next_r         = r;
    next_r.cs_s    = {r.cs_s[0], i_cs_n};
    next_r.st_s    = {r.st_s[0], i_start_n};
    next_r.rd_s    = {r.rd_s[0], i_rd_n};
    next_r.st_prev = r.st_s[1];
    // coarse phase of the converter, steers the search branch
    case (r.phase)
      st_idle: begin
        if (start_req) next_r.phase = st_hold;
      end
      st_hold: begin
        if (!start_req) next_r.phase = st_arm; // RL6
      end
      st_arm: begin
        if (start_req) begin
          next_r.phase = st_hold;
        end else if (tk.tick && r.start_ff) begin
          next_r.phase = st_conv; // RL7
        end
      end
      st_conv: begin
        if (start_req) begin
          next_r.phase = st_hold; // RL3
        end else if (tk.tick && marker_out) begin
          next_r.phase = st_idle;
        end
      end
      default: next_r.phase = st_idle;
    endcase
    // falling start edge wipes the search state
    if (r.st_prev && !r.st_s[1]) begin
      next_r.approx_register = '0; // RL5
      next_r.shifter         = '0; // RL5
    end
    if (start_req) begin
      // a running conversion is abandoned here
      next_r.start_ff         = 1'b1; // RL8 RL3
      next_r.shifter          = '0; // RL6
      next_r.approx_register  = '0; // RL6
      next_r.shift_entry_flop = 1'b1; // RL8
      next_r.conversion_done_n_ff          = 1'b0; // RL8
      next_r.end_latch        = 1'b0;
      next_r.set_pend         = 1'b0; // RL13
      next_r.set_cnt          = '0;
    end else if (tk.tick) begin
      if (r.start_ff) begin
        // gated tick clears start only once request is gone
        if (r.shift_entry_flop) begin
          next_r.start_ff = 1'b0; // RL9 RL17 RL7
          next_r.shifter  = {{BITS{1'b0}}, 1'b1};
          next_r.shift_entry_flop = 1'b0;
          next_r.approx_register  = '0;
          next_r.trial    = {1'b1, {(BITS-1){1'b0}}}; // RL1
        end
      end else if (r.phase == st_conv && |r.shifter[BITS-1:0]) begin
        // one comparison per internal tick, MSB first
        next_r.approx_register = next_approx_bit; // RL1
        next_r.trial           = next_trial_bit; // RL1
        next_r.shifter = {r.shifter[BITS-1:0], 1'b0}; // RL10
      end else if (marker_out) begin
        // result moves to output latch before interrupt
        next_r.result    = r.approx_register; // RL11 RL2
        next_r.shifter   = '0;
        next_r.end_latch = 1'b1;
      end else if (r.end_latch) begin
        next_r.end_latch = 1'b0;
        next_r.set_pend  = 1'b1; // RL11
        next_r.set_cnt   = 4'(`SAR_DIV_RATIO); // RL12
      end
    end
    // set pulse holds interrupt for eight external periods
    if (r.set_pend && !start_req) begin
      next_r.conversion_done_n_ff = 1'b1; // RL12
      if (r.set_cnt == 4'h1) begin
        next_r.set_pend = 1'b0;
      end
      next_r.set_cnt = r.set_cnt - 4'h1;
    end else if (rd_req && !start_req) begin
      next_r.conversion_done_n_ff = 1'b0; // RL14
    end
    next_r.done_n = !next_r.conversion_done_n_ff; // RL4 RL13
    next_r.oe     = rd_req; // RL14 RL18
    next_r.dout   = r.result; // RL14
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r        <= '0;
      r.cs_s   <= 2'b11;
      r.st_s   <= 2'b11;
      r.rd_s   <= 2'b11;
      r.st_prev <= 1'b1;
      r.result <= `SAR_RESULT_RESET;
      r.done_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign o_conversion_done_n = r.done_n;
  assign o_data              = r.dout;
  assign o_data_oe           = r.oe;
  assign o_trial             = r.trial;
endmodule : sar_adc_conversion_control

// file: core/sar_tick_div.sv
// Purpose: divide external clock by eight into an internal tick
// Assumes: restart is synchronous to i_clk
// Notes:   restart realigns phase so start latency stays bounded
`timescale 1ns/10ps
`include "sar_ctl_defines.svh"
module sar_tick_div #(
  parameter int RATIO = `SAR_DIV_RATIO
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // tick output
  tick_if.src       tk
);
  typedef struct packed {
    logic [$clog2(RATIO)-1:0] cnt;
    logic                     tick;
  } div_type;
  div_type r, next_r;
  initial begin
    if (RATIO < 2) $error("ratio too small");
  end
  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (tk.restart) begin
      // phase realigned while a start is held
      next_r.cnt = '0;
    end else if (r.cnt == $bits(r.cnt)'(RATIO - 1)) begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1; // RL10
    end else begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) r <= '0;
    else r <= next_r;
  end
  assign tk.tick = r.tick;
endmodule : sar_tick_div

// file: pkg/sar_ctl_defines.svh
// Purpose: constants for the successive-approximation conversion control
// Assumes: 40 MHz system clock
// Notes:   definitions only
`ifndef SAR_CTL_DEFINES_SVH
`define SAR_CTL_DEFINES_SVH
`define SAR_RES_BITS       8
`define SAR_DIV_RATIO      8
`define SAR_FULL_SCALE     8'hFF
`define SAR_RESULT_RESET   8'h00
`define SAR_CONVERSION_DONE_N_SHORT_NS  300
`define SAR_CLK_NS         25
`define SAR_CONVERSION_DONE_N_SHORT_CYC ((`SAR_CONVERSION_DONE_N_SHORT_NS) / (`SAR_CLK_NS))
`endif

// file: pkg/sar_ctl_pkg.sv
// Purpose: types for the conversion control
// Assumes: constants come from sar_ctl_defines.svh
// Notes:   none
package sar_ctl_pkg;
  typedef logic [7:0] sample_type;
  typedef enum logic [1:0] {st_idle, st_hold, st_arm, st_conv} phase_type;
endpackage : sar_ctl_pkg

// file: pkg/tick_if.sv
// Purpose: carries the internal clock enable between modules
// Assumes: one clock domain
// Notes:   tick is one system cycle wide
`timescale 1ns/10ps
interface tick_if;
  logic tick;
  logic restart;
  modport src (output tick, input restart);
  modport dst (input tick, output restart);
endinterface : tick_if

// file: verif/sar_adc_conversion_control_bench.sv
// Purpose: self-checking bench for the conversion control
// Assumes: comparator model gives exact codes
// Notes:   free run ties done to start
`timescale 1ns/10ps
module sar_adc_conversion_control_bench;
  import sar_ctl_pkg::*;
  logic i_clk = 0, i_rstn = 0, i_cs_n = 1, i_rd_n = 1, sdrv = 1, free = 0;
  logic [7:0] level = 0;
  wire        i_cmp_high, o_conversion_done_n, o_data_oe;
  wire  [7:0] o_trial;
  sample_type o_data;
  wire        i_start_n = free ? o_conversion_done_n : sdrv;
  int         n_fail = 0, cmp_count = 0;
  sar_adc_conversion_control u_sar_adc_conversion_control (.i_clk,
    .i_rstn, .i_cs_n, .i_start_n, .i_rd_n, .i_cmp_high, .o_trial,
    .o_conversion_done_n, .o_data, .o_data_oe);
  sar_cmp_model u_sar_cmp_model (.i_level(level), .i_trial(o_trial),
    .o_high(i_cmp_high));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic cyc(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic start(logic [7:0] v);
    level <= v;
    {i_cs_n, sdrv} <= 2'b00;
    cyc(6);
    {i_cs_n, sdrv} <= 2'b11;
  endtask : start
  task automatic wait_done(output int c);
    for (c = 0; o_conversion_done_n !== 0 && c < 300; c++) cyc(1);
  endtask : wait_done
  task automatic t_conv(logic [7:0] v);
    int c;
    start(v);
    wait_done(c);
    chk("latency", 1, c >= 72 && c < 130);
    cyc(9);
    {i_cs_n, i_rd_n} <= 2'b00;
    cyc(4);
    chk("oe", 1, o_data_oe);
    chk("data", v, o_data);
    {i_cs_n, i_rd_n} <= 2'b11;
    cyc(4);
    chk("done", 1, o_conversion_done_n);
    chk("idle oe", 0, o_data_oe);
    $display("test conv %h done", v);
  endtask : t_conv
  task automatic t_abort();
    start(8'h3c);
    cyc(40);
    t_conv(8'h5a);
  endtask : t_abort
  task automatic t_hold();
    int c;
    start(8'h11);
    wait_done(c);
    {i_cs_n, sdrv} <= 2'b00;
    cyc(200);
    chk("held done", 1, o_conversion_done_n);
    {i_cs_n, sdrv} <= 2'b11;
    wait_done(c);
    chk("released", 1, c >= 72 && c < 130);
    $display("test hold done");
  endtask : t_hold
  task automatic t_free();
    int n = 0;
    logic p = 1;
    start(8'hc3);
    free <= 1;
    {i_cs_n, i_rd_n} <= 2'b00;
    repeat (600) begin
      cyc(1);
      n += p && !o_conversion_done_n;
      p = o_conversion_done_n;
    end
    chk("runs", 1, n >= 5);
    chk("free data", 8'hc3, o_data);
    free <= 0;
    {i_cs_n, i_rd_n} <= 2'b11;
    $display("test free done");
  endtask : t_free
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude
  initial begin
    cyc(3);
    i_rstn <= 1;
    cyc(3);
    t_conv(8'hff);
    t_conv(8'h00);
    t_conv(8'ha5);
    t_abort();
    t_hold();
    t_free();
    conclude();
  end
  initial begin
    #(25 * 20000);
    n_fail++;
    conclude();
  end
endmodule : sar_adc_conversion_control_bench
bind sar_adc_conversion_control sar_ctl_chk #(.BITS(BITS)) u_sar_ctl_chk (
  .i_clk, .i_rstn, .i_cs_n, .i_start_n, .i_rd_n, .o_trial,
  .o_conversion_done_n, .o_data_oe, .o_data);

// file: verif/sar_cmp_model.sv
// Purpose: comparator seen by the converter
// Assumes: high when level is at or above trial
// Notes:   none
`timescale 1ns/10ps
module sar_cmp_model (
  input  wire logic [7:0] i_level,
  input  wire logic [7:0] i_trial,
  output logic            o_high
);
  assign o_high = i_level >= i_trial;
endmodule : sar_cmp_model

// file: verif/sar_ctl_chk.sv
// Purpose: port checks for the conversion control
// Assumes: sync plus register is three edges
// Notes:   none
`timescale 1ns/10ps
module sar_ctl_chk #(parameter int BITS = 8) (
  input wire logic            i_clk, i_rstn, i_cs_n, i_start_n, i_rd_n,
  input wire logic [BITS-1:0] o_trial,
  input wire logic            o_conversion_done_n, o_data_oe,
  input sar_ctl_pkg::sample_type o_data
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  wire rd = !i_cs_n && !i_rd_n;
  wire go = !i_cs_n && !i_start_n;
  sequence s_quiet; o_conversion_done_n throughout ##60 1'b1; endsequence
  sequence s_done; ##[1:80] !o_conversion_done_n; endsequence
  property p_hiz; (!rd)[*4] |-> !o_data_oe; endproperty
  property p_drive; rd[*4] |-> o_data_oe; endproperty
  property p_hold; go[*8] |-> o_conversion_done_n; endproperty
  property p_pulse;
    $fell(o_conversion_done_n) && i_start_n |-> !o_conversion_done_n[*8];
  endproperty
  property p_free;
    $fell(o_conversion_done_n) && go |-> ##[1:10] o_conversion_done_n;
  endproperty
  property p_conv;
    $rose(i_start_n) && !i_cs_n |-> s_quiet ##0 s_done;
  endproperty
  property p_msb;
    $rose(i_start_n) && !i_cs_n |-> ##[1:30] o_trial == 8'h80;
  endproperty
  property p_latch; $fell(o_conversion_done_n) |-> $stable(o_data);
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("data driven without read");
  a_drive: assert property (p_drive)
    else $error("data not driven on read");
  a_hold: assert property (p_hold)
    else $error("done during held start");
  a_pulse: assert property (p_pulse)
    else $error("done pulse too short");
  a_free: assert property (p_free)
    else $error("free run pulse too long");
  a_conv: assert property (p_conv)
    else $error("conversion time wrong");
  a_msb: assert property (p_msb)
    else $error("first trial not msb");
  a_latch: assert property (p_latch)
    else $error("data moved with done");
endmodule : sar_ctl_chk
